/* design/adcpc_controller.sv */
/*
 * Control and host interface of a six-channel 12-bit successive-approximation
 * converter: control byte capture, acquisition and conversion sequencing,
 * completion flag and three-state result bus.
 * Assumes host strobes synchronous to ref_clk and the analog core outside
 * supplying one comparator decision per conversion clock.
 */
// Notes on behaviour
// - Internal acquisition: write rising edge latches byte, acquires, then converts.
// - External acquisition: first write starts acquiring, write with bit clear converts.
// - Select high: strobes ignored and data pins released.
// - Host selects and drops read; device then drives the result.
// - Result on twelve lines, highest line is the most significant bit.
// - Timed acquisition lasts six conversion clocks, then hold and convert.
// - Every conversion lasts twelve conversion clocks.
// - A write during conversion abandons it and starts a fresh acquisition.
// - Second byte with acquisition bit set restarts an unbounded acquisition.
// - Control byte taken from the low eight data lines.
// - Byte: bits 7-6 power mode, 5 acquisition, 4 span, 3 polarity, 2-0 channel.
// - Mode 00 external clock, 01 internal, 10 standby, 11 deep; sleep keeps clock.
// - Polarity and span pick one of four input spans.
// - Channel codes 0 to 5 pick inputs 0 to 5; codes 6 and 7 select no input.
// - Unipolar results straight binary, bipolar results two's complement.
// - Completion flag drops at conversion end, rises on read or write.
// - After reset: normal mode, external clock, completion flag high.
// - Sleep waits for conversion end; bus stays usable; write falling edge wakes.
`timescale 1ns/1ps
`include "adcpc_defs.svh"
module adcpc_controller #(
	parameter int CLK_DIV = `ADCPC_CLK_DIV_DEFAULT
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        chipSel_n,
	input  wire logic        writeStrobe_n,
	input  wire logic        readStrobe_n,
	input  wire logic [11:0] parallelDataBusIn,
	output logic      [11:0] parallelDataBusOut,
	output logic      [11:0] parallelDataBusOe,
	output logic             convDone_n,
	input  wire logic        extConvClk,
	input  wire logic        compareHigh,
	output logic      [5:0]  analogInputs,
	output logic             trackHold,
	output logic      [11:0] dacTrial,
	output logic             spanSelect,
	output logic             polaritySelect,
	output logic             standbySleep,
	output logic             deepSleep,
	output logic             internalClkSel
);
	adcpc_result_if res ();

	adcpc_result_store u_store (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.res     (res)
	);

	adcpc_pkg::adcpc_state_e stateReg;
	logic [7:0]  ctrlReg;
	logic        wrPrevReg;
	logic        rdPrevReg;
	logic        extClkPrevReg;
	logic [$clog2(CLK_DIV)-1:0] divCntReg;
	logic [3:0]  cycCntReg;
	logic [11:0] sarReg;
	logic [1:0]  clkModeReg;
	logic        sleepPendReg;
	logic [1:0]  sleepReqReg;

	// Strobes only count while selected
	logic wrRise;
	logic wrFall;
	logic rdFall;
	logic rdActive;
	logic convTick;
	logic lastConv;
	logic [7:0] wrByte;

	assign wrRise   = !chipSel_n && !wrPrevReg && writeStrobe_n;
	assign wrFall   = !chipSel_n && wrPrevReg && !writeStrobe_n;
	assign rdFall   = !chipSel_n && rdPrevReg && !readStrobe_n;
	assign rdActive = !chipSel_n && !readStrobe_n;
	assign wrByte   = parallelDataBusIn[7:0];
	assign lastConv = (stateReg == adcpc_pkg::ADCPC_ST_CONVERT) && convTick
		&& (cycCntReg == 4'(`ADCPC_CONV_CYCLES - 1));

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrPrevReg     <= 1'b1;
			rdPrevReg     <= 1'b1;
			extClkPrevReg <= 1'b0;
		end else begin
			wrPrevReg     <= writeStrobe_n;
			rdPrevReg     <= readStrobe_n;
			extClkPrevReg <= extConvClk;
		end
	end

	// Conversion clock: external pin edge or internal divider, as one-cycle enable
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			divCntReg <= '0;
		end else if (divCntReg == ($clog2(CLK_DIV))'(CLK_DIV - 1)) begin
			divCntReg <= '0;
		end else begin
			divCntReg <= divCntReg + 1'b1;
		end
	end

	always_comb begin
		if (clkModeReg == adcpc_pkg::ADCPC_PWR_INT_CLK) begin
			convTick = (divCntReg == ($clog2(CLK_DIV))'(CLK_DIV - 1));
		end else begin
			convTick = extConvClk && !extClkPrevReg;
		end
	end

	// Control byte capture; sleep codes leave the clock mode alone
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrlReg    <= `ADCPC_CTRL_RESET;
			clkModeReg <= adcpc_pkg::ADCPC_PWR_EXT_CLK;
		end else if (wrRise) begin
			ctrlReg <= wrByte;
			if (!wrByte[`ADCPC_CTRL_PWR_HI_BIT]) begin
				clkModeReg <= wrByte[`ADCPC_CTRL_PWR_HI_BIT:`ADCPC_CTRL_PWR_LO_BIT];
			end
		end
	end

	// Sequencer: a write restarts acquisition, aborting any conversion, except a write with acquisition bit clear during host acquisition, which converts
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stateReg  <= adcpc_pkg::ADCPC_ST_IDLE;
			cycCntReg <= '0;
		end else if (wrRise) begin
			cycCntReg <= '0;
			if (stateReg == adcpc_pkg::ADCPC_ST_ACQ_HOST && !wrByte[`ADCPC_CTRL_ACQ_BIT]) begin
				stateReg <= adcpc_pkg::ADCPC_ST_CONVERT;
			end else if (wrByte[`ADCPC_CTRL_ACQ_BIT]) begin
				stateReg <= adcpc_pkg::ADCPC_ST_ACQ_HOST;
			end else begin
				stateReg <= adcpc_pkg::ADCPC_ST_ACQ_TIMED;
			end
		end else if (convTick) begin
			case (stateReg)
				adcpc_pkg::ADCPC_ST_ACQ_TIMED: begin
					if (cycCntReg == 4'(`ADCPC_ACQ_CYCLES - 1)) begin
						stateReg  <= adcpc_pkg::ADCPC_ST_CONVERT;
						cycCntReg <= '0;
					end else begin
						cycCntReg <= cycCntReg + 1'b1;
					end
				end
				adcpc_pkg::ADCPC_ST_CONVERT: begin
					if (lastConv) begin
						stateReg  <= adcpc_pkg::ADCPC_ST_IDLE;
						cycCntReg <= '0;
					end else begin
						cycCntReg <= cycCntReg + 1'b1;
					end
				end
				adcpc_pkg::ADCPC_ST_ACQ_HOST: stateReg <= stateReg;
				adcpc_pkg::ADCPC_ST_IDLE:     stateReg <= stateReg;
				default: stateReg <= adcpc_pkg::ADCPC_ST_IDLE;
			endcase
		end
	end

	// Binary search, one decision per conversion clock, MSB first
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sarReg <= `ADCPC_RESULT_RESET;
		end else if (stateReg != adcpc_pkg::ADCPC_ST_CONVERT) begin
			sarReg <= `ADCPC_RESULT_RESET;
		end else if (convTick) begin
			sarReg[4'(11) - cycCntReg] <= compareHigh;
		end
	end

	// Offset-binary search result flipped to two's complement for bipolar spans
	logic [11:0] finalWord;
	always_comb begin
		finalWord = sarReg;
		finalWord[4'(11) - cycCntReg] = compareHigh;
		if (ctrlReg[`ADCPC_CTRL_POL_BIT]) begin
			finalWord[11] = ~finalWord[11];
		end
	end

	assign res.storeEn   = lastConv && !wrRise;
	assign res.storeWord = finalWord;

	// Completion flag: a new end wins over a simultaneous read
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			convDone_n <= 1'b1;
		end else if (res.storeEn) begin
			convDone_n <= 1'b0;
		end else if (rdFall || wrRise) begin
			convDone_n <= 1'b1;
		end
	end

	// Sleep is latched per write, applied only when no conversion is running
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sleepPendReg <= 1'b0;
			sleepReqReg  <= 2'b00;
			standbySleep <= 1'b0;
			deepSleep    <= 1'b0;
		end else begin
			if (wrFall) begin
				standbySleep <= 1'b0;
				deepSleep    <= 1'b0;
				sleepPendReg <= 1'b0;
			end else if (wrRise) begin
				sleepPendReg <= wrByte[`ADCPC_CTRL_PWR_HI_BIT];
				sleepReqReg  <= {wrByte[`ADCPC_CTRL_PWR_HI_BIT], wrByte[`ADCPC_CTRL_PWR_LO_BIT]};
			end else if (sleepPendReg && stateReg == adcpc_pkg::ADCPC_ST_IDLE) begin
				sleepPendReg <= 1'b0;
				standbySleep <= (sleepReqReg == adcpc_pkg::ADCPC_PWR_STANDBY);
				deepSleep    <= (sleepReqReg == adcpc_pkg::ADCPC_PWR_DEEP);
			end
		end
	end

	// One select line per input; codes 6 and 7 leave every input off
	for (genvar ch = 0; ch < `ADCPC_CHAN_COUNT; ch++) begin : g_chan
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				analogInputs[ch] <= 1'(ch == 0);
			end else begin
				analogInputs[ch] <= (ctrlReg[`ADCPC_CTRL_CHAN_HI:`ADCPC_CTRL_CHAN_LO]
					== 3'(ch));
			end
		end
	end

	// Analog-side controls, all registered
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			trackHold      <= 1'b0;
			dacTrial       <= `ADCPC_RESULT_RESET;
			spanSelect     <= 1'b0;
			polaritySelect <= 1'b0;
			internalClkSel <= 1'b0;
		end else begin
			trackHold      <= (stateReg == adcpc_pkg::ADCPC_ST_ACQ_TIMED)
				|| (stateReg == adcpc_pkg::ADCPC_ST_ACQ_HOST);
			dacTrial       <= sarReg | (12'h800 >> cycCntReg);
			spanSelect     <= ctrlReg[`ADCPC_CTRL_SPAN_BIT];
			polaritySelect <= ctrlReg[`ADCPC_CTRL_POL_BIT];
			internalClkSel <= (clkModeReg == adcpc_pkg::ADCPC_PWR_INT_CLK);
		end
	end

	// Data pins driven only while selected and reading
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			parallelDataBusOut <= `ADCPC_RESULT_RESET;
			parallelDataBusOe  <= 12'h000;
		end else begin
			parallelDataBusOut <= res.heldWord;
			parallelDataBusOe  <= {12{rdActive}};
		end
	end

	// Helper: conversion clock ticks spent in the current conversion
	logic [4:0] convTicks;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			convTicks <= '0;
		end else if (stateReg != adcpc_pkg::ADCPC_ST_CONVERT || wrRise) begin
			convTicks <= '0;
		end else if (convTick) begin
			convTicks <= convTicks + 1'b1;
		end
	end

	conv_length_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		res.storeEn |-> convTicks == 5'd11)
		else $error("conversion did not take twelve clocks");

	acq_timed_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(stateReg == adcpc_pkg::ADCPC_ST_ACQ_TIMED && convTick && !wrRise
			&& cycCntReg == 4'd5) |=> stateReg == adcpc_pkg::ADCPC_ST_CONVERT)
		else $error("timed acquisition not six clocks");

	host_acq_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(wrRise && parallelDataBusIn[5]) |=> stateReg == adcpc_pkg::ADCPC_ST_ACQ_HOST)
		else $error("host acquisition not started");

	abort_conv_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(wrRise && stateReg == adcpc_pkg::ADCPC_ST_CONVERT && !parallelDataBusIn[5])
			|=> stateReg == adcpc_pkg::ADCPC_ST_ACQ_TIMED)
		else $error("write did not abort conversion");

	bus_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		chipSel_n |=> parallelDataBusOe == 12'h000)
		else $error("bus driven while deselected");

	read_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!chipSel_n && !readStrobe_n) |=> parallelDataBusOe == 12'hFFF)
		else $error("bus not driven on read");

	done_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		res.storeEn |=> !convDone_n ##0 (rdFall || wrRise || !convDone_n))
		else $error("completion flag not low after conversion");

	done_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(rdFall && !res.storeEn) |=> convDone_n)
		else $error("completion flag not cleared by read");

	clk_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(wrRise && parallelDataBusIn[7]) |=> $stable(clkModeReg))
		else $error("sleep code changed the clock mode");

	wake_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wrFall |=> !standbySleep && !deepSleep)
		else $error("write did not end sleep");

	conv_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(stateReg == adcpc_pkg::ADCPC_ST_CONVERT) |=> !trackHold)
		else $error("track/hold not holding during conversion");

	deselect_ignore_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		chipSel_n |=> $stable(ctrlReg))
		else $error("strobe acted while deselected");

	span_bits_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wrRise |-> ##2 (spanSelect == $past(parallelDataBusIn[`ADCPC_CTRL_SPAN_BIT], 2)
			&& polaritySelect == $past(parallelDataBusIn[`ADCPC_CTRL_POL_BIT], 2)))
		else $error("span or polarity not taken from the byte");

	int_clk_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(wrRise && !parallelDataBusIn[`ADCPC_CTRL_PWR_HI_BIT]) |-> ##2
			(internalClkSel == $past(parallelDataBusIn[`ADCPC_CTRL_PWR_LO_BIT], 2)))
		else $error("clock mode not taken from the byte");

endmodule : adcpc_controller

/* design/adcpc_defs.svh */
/*
 * Constants of the parallel-bus converter controller: control byte field positions,
 * reset values, cycle counts, default clock divider and channel count.
 * Assumes it is included by its bare name from design files only.
 */
`ifndef ADCPC_DEFS_SVH
`define ADCPC_DEFS_SVH

`define ADCPC_CTRL_PWR_HI_BIT   7
`define ADCPC_CTRL_PWR_LO_BIT   6
`define ADCPC_CTRL_ACQ_BIT      5
`define ADCPC_CTRL_SPAN_BIT     4
`define ADCPC_CTRL_POL_BIT      3
`define ADCPC_CTRL_CHAN_HI      2
`define ADCPC_CTRL_CHAN_LO      0
`define ADCPC_CTRL_RESET        8'h00
`define ADCPC_RESULT_RESET      12'h000
`define ADCPC_ACQ_CYCLES        6
`define ADCPC_CONV_CYCLES       12
`define ADCPC_CLK_DIV_DEFAULT   20
`define ADCPC_CHAN_COUNT        6

`endif

/* design/adcpc_pkg.sv */
/*
 * Types shared by the converter controller and its result store.
 * Assumes nothing beyond the defs header for numbers.
 */
package adcpc_pkg;

	typedef enum logic [1:0] {
		ADCPC_PWR_EXT_CLK,
		ADCPC_PWR_INT_CLK,
		ADCPC_PWR_STANDBY,
		ADCPC_PWR_DEEP
	} adcpc_pwr_e;

	typedef enum logic [2:0] {
		ADCPC_ST_IDLE,
		ADCPC_ST_ACQ_TIMED,
		ADCPC_ST_ACQ_HOST,
		ADCPC_ST_CONVERT
	} adcpc_state_e;

	typedef logic [11:0] adcpc_word_t;

endpackage : adcpc_pkg

/* design/adcpc_result_if.sv */
/*
 * Carrier between the controller and its result store: a write strobe with the
 * finished word, and the stored word back.
 * Assumes one clock domain, driven by the controller.
 */
`timescale 1ns/1ps
interface adcpc_result_if;
	logic                 storeEn;
	adcpc_pkg::adcpc_word_t storeWord;
	adcpc_pkg::adcpc_word_t heldWord;

	modport ctrl  (output storeEn, output storeWord, input heldWord);
	modport store (input storeEn, input storeWord, output heldWord);
endinterface : adcpc_result_if

/* design/adcpc_result_store.sv */
/*
 * Holds the most recent completed conversion result; read data from a register.
 * Assumes the controller pulses storeEn once per finished conversion.
 */
`timescale 1ns/1ps
`include "adcpc_defs.svh"
module adcpc_result_store (
	input  wire logic    ref_clk,
	input  wire logic    rstn,
	adcpc_result_if.store res
);
	adcpc_pkg::adcpc_word_t heldReg;

	// Kept until replaced, so reads during later acquisitions still see it
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			heldReg <= `ADCPC_RESULT_RESET;
		end else if (res.storeEn) begin
			heldReg <= res.storeWord;
		end
	end

	assign res.heldWord = heldReg;

	held_word_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!res.storeEn |=> $stable(heldReg))
		else $error("result changed without a store");

endmodule : adcpc_result_store

/* verif/adcpc_host_model.sv */
/*
 * Host processor model on the converter's parallel bus: write and read cycles.
 * Assumes the bench calls its tasks just after a falling edge of ref_clk.
 */
`timescale 1ns/1ps
module adcpc_host_model (
	input  wire logic        ref_clk,
	input  wire logic [11:0] busSeen,
	input  wire logic        oeSeen,
	output logic             chipSel_n,
	output logic             writeStrobe_n,
	output logic             readStrobe_n,
	output logic      [11:0] hostData,
	output logic             hostOe
);
	initial begin
		chipSel_n = 1'b1;
		writeStrobe_n = 1'b1;
		readStrobe_n = 1'b1;
		hostData = 12'h000;
		hostOe = 1'b0;
	end

	// Upper lines carry junk so a byte taken from them shows up
	task automatic write_byte(input logic [7:0] b, input logic sel);
		@(negedge ref_clk);
		chipSel_n = ~sel;
		writeStrobe_n = 1'b0;
		hostData = {~b[3:0], b};
		hostOe = 1'b1;
		@(negedge ref_clk);
		writeStrobe_n = 1'b1;
		@(negedge ref_clk);
		chipSel_n = 1'b1;
		hostOe = 1'b0;
		@(negedge ref_clk);
	endtask : write_byte

	task automatic read_word(output logic [11:0] w, output logic o, input logic sel);
		@(negedge ref_clk);
		chipSel_n = ~sel;
		readStrobe_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		w = busSeen;
		o = oeSeen;
		readStrobe_n = 1'b1;
		chipSel_n = 1'b1;
		@(negedge ref_clk);
	endtask : read_word
endmodule : adcpc_host_model

/* verif/test_adc_parallel_conversion_control.sv */
/*
 * Self-checking bench of the converter controller, host model on the bus side.
 * Assumes CLK_DIV of 2 and a free external conversion clock of four ref_clk cycles.
 */
`timescale 1ns/1ps
module test_adc_parallel_conversion_control;
	localparam int DIV = 2;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        extConvClk = 1'b0;
	logic        compareHigh = 1'b0;
	logic        chipSel_n, writeStrobe_n, readStrobe_n, hostOe, convDone_n, trackHold;
	logic        spanSelect, polaritySelect, standbySleep, deepSleep, internalClkSel, o;
	logic        intMode = 1'b0;
	logic [11:0] hostData, busIn, dutOut, dutOe, w, trial;
	logic [5:0]  analogInputs;
	int          seed = 32'hf3e5b5b1;
	int          err_total = 0;
	int          comparisons = 0;
	int          n, i;

	always #12.5 ref_clk = ~ref_clk;
	always begin
		repeat (2) @(negedge ref_clk);
		extConvClk <= ~extConvClk;
	end
	// A released bus shows the inverse of the host's last value, never a kind 0 or 1
	assign busIn = dutOe[0] ? dutOut : (hostOe ? hostData : ~hostData);

	adcpc_controller #(.CLK_DIV(DIV)) dut (.ref_clk(ref_clk), .rstn(rstn),
		.chipSel_n(chipSel_n), .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
		.parallelDataBusIn(busIn), .parallelDataBusOut(dutOut), .parallelDataBusOe(dutOe),
		.convDone_n(convDone_n), .extConvClk(extConvClk), .compareHigh(compareHigh),
		.analogInputs(analogInputs), .trackHold(trackHold), .dacTrial(trial),
		.spanSelect(spanSelect), .polaritySelect(polaritySelect),
		.standbySleep(standbySleep), .deepSleep(deepSleep), .internalClkSel(internalClkSel));

	adcpc_host_model host (.ref_clk(ref_clk), .busSeen(busIn), .oeSeen(dutOe[0]),
		.chipSel_n(chipSel_n), .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
		.hostData(hostData), .hostOe(hostOe));

	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Constant comparator answer gives all ones or zeros; bipolar flips the top bit
	function automatic logic [11:0] exp_word(input logic c, input logic polarity_select);
		return {12{c}} ^ {polarity_select, 11'h000};
	endfunction : exp_word

	function automatic int span(input int ticks);
		return ticks * (intMode ? DIV : 4);
	endfunction : span

	task automatic wait_done(output int c);
		c = 0;
		while (convDone_n !== 1'b0 && c < 400) begin
			@(negedge ref_clk);
			c++;
		end
	endtask : wait_done

	task automatic in_window(input int c, input int ticks);
		check(12'(c >= span(ticks) - 8 && c <= span(ticks) + 8), 12'h001);
	endtask : in_window

	task automatic convert(input logic [7:0] cb, input logic rd);
		compareHigh = 1'($random(seed));
		if (!cb[7])
			intMode = cb[6];
		host.write_byte(cb, 1'b1);
		check(12'(analogInputs), (cb[2:0] < 3'd6) ? 12'(6'h01 << cb[2:0]) : 12'h000);
		check(12'({spanSelect, polaritySelect}), 12'(cb[4:3]));
		wait_done(n);
		in_window(n, 18);
		if (rd) begin
			host.read_word(w, o, 1'b1);
			check(w, exp_word(compareHigh, cb[3]));
			check(12'(convDone_n), 12'h001);
		end
	endtask : convert

	task automatic results;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	initial begin
		repeat (10) @(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		check(12'({convDone_n, internalClkSel, analogInputs}), 12'h081);
		check(trial, 12'h800);
		check(dutOe, 12'h000);
		for (i = 0; i < 16; i++)
			convert({1'b0, i[3], 1'b0, i[2:1], i[2:0]}, 1'b1);
		convert(8'h41, 1'b0);
		host.write_byte(8'h07, 1'b0);
		host.read_word(w, o, 1'b0);
		check(12'({o, convDone_n, analogInputs}), 12'h002);
		host.read_word(w, o, 1'b1);
		host.read_word(w, o, 1'b1);
		check(w, exp_word(compareHigh, 1'b0));
		check(12'(convDone_n), 12'h001);
		// Second byte lands mid-conversion, so completion waits a full new sequence
		host.write_byte(8'h40, 1'b1);
		repeat (22) @(negedge ref_clk);
		convert(8'h42, 1'b1);
		// Host-timed acquisition with the same channel bits in both bytes
		host.write_byte(8'h61, 1'b1);
		repeat (80) @(negedge ref_clk);
		check(12'({convDone_n, trackHold}), 12'h003);
		host.write_byte(8'h61, 1'b1);
		repeat (60) @(negedge ref_clk);
		check(12'({convDone_n, trackHold}), 12'h003);
		compareHigh = 1'($random(seed));
		host.write_byte(8'h41, 1'b1);
		wait_done(n);
		in_window(n, 12);
		host.read_word(w, o, 1'b1);
		check(w, exp_word(compareHigh, 1'b0));
		convert(8'h81, 1'b1);
		check(12'({standbySleep, deepSleep, internalClkSel}), 12'h005);
		convert(8'hCA, 1'b1);
		check(12'({standbySleep, deepSleep, internalClkSel}), 12'h003);
		convert(8'h03, 1'b1);
		check(12'({standbySleep, deepSleep, internalClkSel}), 12'h000);
		results();
	end

	// Whole sequence needs under 5000 cycles
	initial begin
		#(25 * 20000);
		err_total++;
		results();
	end
endmodule : test_adc_parallel_conversion_control
